/* pcs_status_regs.sv */
/*
 * Configuration header status, revision, class code and header type.
 * Assumes the PCI target engine presents decoded dword configuration cycles,
 * one-cycle event pulses from the bridge logic, and an external PCI reset pin.
 */
// Summary of operation
// - Status flags set only by hardware events, never by software writes.
// - Bit 14 sets when the system error line is driven.
// - Bit 13 sets on master abort received; write one clears.
// - Bit 12 sets on target abort received; write one clears.
// - Bit 11 sets on target abort signalled; write one clears.
// - Bits 10:9 always read 01b, medium decode; writes ignored.
// - Claim configuration positively; others subtractively, qualified by isa target indication.
// - Bits 15, 8, 7, 5 read zero; no parity checking.
// - Bit 6 reads zero; 33 MHz maximum.
// - Revision register returns fixed 8-bit value, ignores writes.
// - Class code always reads 060100h.
// - Class code writes accepted but leave contents unchanged.
// - Header type reads 00h: single function, layout 00.
// - Byte, word, dword accesses; little-endian byte ordering.
// - PCI reset returns all registers to defaults, clearing flags unless an event sets one in the same cycle.
`timescale 1ns/1ns
`include "pcs_consts.svh"
module pcs_status_regs
    import pcs_pkg::*;
(
    input  wire logic            i_mclk,
    input  wire logic            i_reset_n,
    input  wire logic            i_ce,
    input  wire logic            i_pci_reset_input_n,
    input  wire pcs_cfg_req_type i_cfg,
    input  wire logic            i_cfg_cycle,
    input  wire logic            i_other_cycle,
    input  wire logic            i_isa_target_indication,
    input  wire pcs_event_type   i_event,
    output logic [31:0]          o_rdata,
    output logic                 o_ack,
    output logic                 o_claim_positive,
    output logic                 o_claim_subtractive
);

    // ****************************************************************
    // Reset pin and ISA target indication synchronisers
    // ****************************************************************
    logic       rst_meta_n;
    logic       rst_sync_n;
    logic       isa_meta;
    logic       isa_sync;

    // The pin is external, so it passes two flops before any use.
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
            isa_meta   <= 1'b0;
            isa_sync   <= 1'b0;
        end else if (i_ce) begin
            rst_meta_n <= i_pci_reset_input_n;
            rst_sync_n <= rst_meta_n;
            isa_meta   <= i_isa_target_indication;
            isa_sync   <= isa_meta;
        end
    end

    // ****************************************************************
    // Sticky status flags
    // ****************************************************************
    logic [15:0] status_rd;
    logic        wr_status_hi;
    logic        flag_serr;
    logic        flag_mabort;
    logic        flag_tabort_rcv;
    logic        flag_tabort_sig;

    // Byte 07h is lane 3 of dword 1, little-endian.
    assign wr_status_hi = i_cfg.wr && i_cfg.byte_en[3]
                          && (i_cfg.dword == `PCS_DWORD_STATUS);

    // Clear only on a write of one; PCI reset clears flags unless an event sets one in that cycle.
    pcs_flag u_flag_serr (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .i_set     (i_event.serr_sig),
        .i_clear   (!rst_sync_n || (wr_status_hi && i_cfg.wdata[16 + `PCS_BIT_SERR_SIG])),
        .o_flag    (flag_serr)
    );
    pcs_flag u_flag_mabort (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .i_set     (i_event.mabort_rcv),
        .i_clear   (!rst_sync_n || (wr_status_hi && i_cfg.wdata[16 + `PCS_BIT_MABORT_RCV])),
        .o_flag    (flag_mabort)
    );
    pcs_flag u_flag_tabort_rcv (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .i_set     (i_event.tabort_rcv),
        .i_clear   (!rst_sync_n || (wr_status_hi && i_cfg.wdata[16 + `PCS_BIT_TABORT_RCV])),
        .o_flag    (flag_tabort_rcv)
    );
    pcs_flag u_flag_tabort_sig (
        .i_mclk    (i_mclk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .i_set     (i_event.tabort_sig),
        .i_clear   (!rst_sync_n || (wr_status_hi && i_cfg.wdata[16 + `PCS_BIT_TABORT_SIG])),
        .o_flag    (flag_tabort_sig)
    );

    // Hardwired zeros cover parity, fast b2b, 66 MHz, user features, reserved.
    always_comb begin
        status_rd       = 16'h0000;
        status_rd[10:9] = `PCS_DECODE_MEDIUM;
        status_rd[`PCS_BIT_SERR_SIG]   = flag_serr;
        status_rd[`PCS_BIT_MABORT_RCV] = flag_mabort;
        status_rd[`PCS_BIT_TABORT_RCV] = flag_tabort_rcv;
        status_rd[`PCS_BIT_TABORT_SIG] = flag_tabort_sig;
    end

    // ****************************************************************
    // Read data and acknowledge
    // ****************************************************************
    logic [31:0] next_rdata;

    // Writes to read-only dwords are acknowledged and discarded.
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (i_cfg.dword)
            `PCS_DWORD_STATUS:   next_rdata = {status_rd, 16'h0000};
            `PCS_DWORD_REVCLASS: next_rdata = {`PCS_CLASS_CODE, `PCS_REVISION_ID};
            `PCS_DWORD_HEADER:   next_rdata = {8'h00, `PCS_HEADER_TYPE, 16'h0000};
            default:             next_rdata = 32'h0000_0000;
        endcase
    end

    // Unselected byte lanes read zero so narrow reads see only their bytes.
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 32'h0000_0000;
            o_ack   <= 1'b0;
        end else if (i_ce) begin
            o_ack <= i_cfg.rd || i_cfg.wr;
            if (i_cfg.rd) begin
                o_rdata <= next_rdata & {{8{i_cfg.byte_en[3]}}, {8{i_cfg.byte_en[2]}},
                                         {8{i_cfg.byte_en[1]}}, {8{i_cfg.byte_en[0]}}};
            end
        end
    end

    // ****************************************************************
    // Decode claim
    // ****************************************************************
    pcs_claim_type claim;

    // Config cycles claim positively; others only when the companion says ISA.
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            claim <= PCS_IDLE;
        end else if (i_ce) begin
            if (i_cfg_cycle) begin
                claim <= PCS_POS_CLAIM;
            end else if (i_other_cycle && isa_sync) begin
                claim <= PCS_SUB_CLAIM;
            end else begin
                claim <= PCS_IDLE;
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_claim_positive    <= 1'b0;
            o_claim_subtractive <= 1'b0;
        end else if (i_ce) begin
            case (claim)
                PCS_POS_CLAIM: begin
                    o_claim_positive    <= 1'b1;
                    o_claim_subtractive <= 1'b0;
                end
                PCS_SUB_CLAIM: begin
                    o_claim_positive    <= 1'b0;
                    o_claim_subtractive <= 1'b1;
                end
                default: begin
                    o_claim_positive    <= 1'b0;
                    o_claim_subtractive <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_reset_n);

    a_serr_sets: assert property (i_ce && i_event.serr_sig |=> flag_serr)
        else $error("system error flag not set");
    a_mabort_clear: assert property (i_ce && rst_sync_n && !i_event.mabort_rcv && wr_status_hi
        && i_cfg.wdata[29] |=> !flag_mabort)
        else $error("master abort flag not cleared");
    a_tabort_rcv_sets: assert property (i_ce && i_event.tabort_rcv |=> flag_tabort_rcv)
        else $error("received target abort flag not set");
    a_tabort_sig_keep: assert property (i_ce && i_event.tabort_sig |=> flag_tabort_sig)
        else $error("signalled target abort lost");
    a_no_soft_set: assert property (!flag_tabort_sig && !i_event.tabort_sig ##1 1
        |-> !flag_tabort_sig)
        else $error("flag set without event");
    a_fixed_bits: assert property (i_ce && i_cfg.rd && i_cfg.dword == 6'h01
        && i_cfg.byte_en[3] && i_cfg.byte_en[2]
        |=> o_rdata[26:25] == 2'b01 && o_rdata[31] == 1'b0 && o_rdata[24:21] == 4'h0
        && o_rdata[20:16] == 5'h00)
        else $error("hardwired status bits wrong");
    a_class_code: assert property (i_ce && i_cfg.rd && i_cfg.dword == 6'h02
        && i_cfg.byte_en == 4'hf |=> o_rdata[31:8] == 24'h06_0100)
        else $error("class code wrong");
    a_header_type: assert property (i_ce && i_cfg.rd && i_cfg.dword == 6'h03
        |=> o_rdata[23:16] == 8'h00)
        else $error("header type wrong");
    // A coincident event still wins over the reset clear, so it is left out here.
    a_pci_reset: assert property (i_ce && !rst_sync_n && !i_event.serr_sig
        && !i_event.mabort_rcv |=> !flag_serr && !flag_mabort)
        else $error("flags survive reset");
    a_claim_sub: assert property (i_ce && !i_cfg_cycle && i_other_cycle && !isa_sync
        ##1 i_ce |=> !o_claim_subtractive)
        else $error("subtractive claim without isa target");

    c_serr: cover property (i_ce && i_event.serr_sig);
    c_clear: cover property (wr_status_hi && flag_mabort);
    c_sub_claim: cover property (o_claim_subtractive);
    c_set_clear_same: cover property (wr_status_hi && i_event.tabort_sig);
endmodule

/* pcs_consts.svh */
/*
 * Offsets, field positions, reset values and fixed identity values for the
 * bridge configuration header status slice.
 * Assumes inclusion by bare name from the status module and the testbench.
 */
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// ****************************************************************
// Register offsets (byte addresses) and dword indices in configuration space
// ****************************************************************
`define PCS_OFF_STATUS      8'h06
`define PCS_OFF_REVISION    8'h08
`define PCS_OFF_CLASS       8'h09
`define PCS_OFF_HEADER      8'h0e
`define PCS_DWORD_STATUS    6'h01
`define PCS_DWORD_REVCLASS  6'h02
`define PCS_DWORD_HEADER    6'h03

// ****************************************************************
// Status field positions and values
// ****************************************************************
`define PCS_BIT_SERR_SIG    14
`define PCS_BIT_MABORT_RCV  13
`define PCS_BIT_TABORT_RCV  12
`define PCS_BIT_TABORT_SIG  11
`define PCS_STATUS_RESET    16'h0200
`define PCS_DECODE_MEDIUM   2'h1

// ****************************************************************
// Fixed register values
// ****************************************************************
`define PCS_CLASS_CODE      24'h06_0100
`define PCS_HEADER_TYPE     8'h00
// Arbitrary neutral revision value.
`define PCS_REVISION_ID     8'h5a

`endif

/* pcs_pkg.sv */
/*
 * Types shared by the status slice modules.
 * Assumes pcs_consts.svh sits in the same folder.
 */
package pcs_pkg;
    // Configuration request from the PCI target engine.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [5:0]  dword;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } pcs_cfg_req_type;

    // Hardware events that set sticky status flags.
    typedef struct packed {
        logic serr_sig;
        logic mabort_rcv;
        logic tabort_rcv;
        logic tabort_sig;
    } pcs_event_type;

    typedef enum logic [1:0] {PCS_IDLE, PCS_POS_CLAIM, PCS_SUB_CLAIM} pcs_claim_type;
endpackage

/* pcs_flag.sv */
/*
 * One sticky write-one-to-clear status flag.
 * Assumes event and clear inputs are synchronous to i_mclk.
 */
`timescale 1ns/1ns
module pcs_flag (
    input  wire logic i_mclk,
    input  wire logic i_reset_n,
    input  wire logic i_ce,
    input  wire logic i_set,
    input  wire logic i_clear,
    output logic      o_flag
);
    // Set wins over clear so an event in the clear cycle is kept.
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_flag <= 1'b0;
        end else if (i_ce) begin
            if (i_set) begin
                o_flag <= 1'b1;
            end else if (i_clear) begin
                o_flag <= 1'b0;
            end
        end
    end
endmodule

/* pcs_host_model.sv */
/*
 * PCI host model that issues configuration reads and writes to the status slice.
 * Assumes one clock and the one-cycle request pulse answered by a registered acknowledge.
 */
`timescale 1ns/1ns
module pcs_host_model
    import pcs_pkg::*;
(
    input  wire logic        i_mclk,
    input  wire logic        i_ack,
    input  wire logic [31:0] i_rdata,
    output pcs_cfg_req_type  o_cfg
);
    // ****************************************************************
    // Configuration cycles
    // ****************************************************************
    // The bus is idle, not unknown, before the first request.
    initial o_cfg = '0;

    // One request pulse, then a bounded wait for the acknowledge.
    // Released dword, enable and data fields show inverted values and rd and wr drop to zero, so stale data never looks valid.
    task automatic xfer(input logic wr, input logic [5:0] dw, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge i_mclk);
        o_cfg <= '{rd: ~wr, wr: wr, dword: dw, byte_en: be, wdata: wd};
        @(posedge i_mclk);
        o_cfg <= '{rd: 1'b0, wr: 1'b0, dword: ~dw, byte_en: ~be, wdata: ~wd};
        for (n = 0; n < 4 && !ok; n++) begin
            @(posedge i_mclk);
            ok = (i_ack === 1'b1);
        end
        rd = i_rdata;
    endtask
endmodule

/* pci_bridge_config_header_status_tb.sv */
/*
 * Self-checking testbench for the configuration header status slice.
 * Assumes the host model drives all configuration cycles and the bench the rest.
 */
`timescale 1ns/1ns
`include "pcs_consts.svh"
module pci_bridge_config_header_status_tb
    import pcs_pkg::*;
;
    logic            i_mclk = 1'b0;
    logic            i_reset_n = 1'b0;
    logic            i_ce = 1'b1;
    logic            i_pci_reset_input_n = 1'b1;
    logic            i_cfg_cycle = 1'b0;
    logic            i_other_cycle = 1'b0;
    logic            i_isa_target_indication = 1'b0;
    pcs_event_type   i_event = '0;
    pcs_cfg_req_type cfg;
    logic [31:0]     o_rdata;
    logic            o_ack;
    logic            o_claim_positive;
    logic            o_claim_subtractive;
    logic [31:0]     rd_val;
    logic            ok;
    int              num_errors = 0;
    int              comparisons = 0;

    // 100 MHz clock.
    always #5 i_mclk = ~i_mclk;

    pcs_status_regs pcs_status_regs_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_ce(i_ce),
        .i_pci_reset_input_n(i_pci_reset_input_n), .i_cfg(cfg), .i_cfg_cycle(i_cfg_cycle),
        .i_other_cycle(i_other_cycle), .i_isa_target_indication(i_isa_target_indication),
        .i_event(i_event), .o_rdata(o_rdata), .o_ack(o_ack),
        .o_claim_positive(o_claim_positive), .o_claim_subtractive(o_claim_subtractive));
    pcs_host_model pcs_host_model_i (.i_mclk(i_mclk), .i_ack(o_ack), .i_rdata(o_rdata),
        .o_cfg(cfg));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Case equality so an unknown never counts as a match.
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic cfg_rd(input logic [5:0] dw, input logic [3:0] be);
        pcs_host_model_i.xfer(1'b0, dw, be, 32'h0000_0000, rd_val, ok);
        check("read ack", {31'h0, ok}, 32'h0000_0001);
    endtask

    task automatic cfg_wr(input logic [5:0] dw, input logic [3:0] be, input logic [31:0] wd);
        pcs_host_model_i.xfer(1'b1, dw, be, wd, rd_val, ok);
        check("write ack", {31'h0, ok}, 32'h0000_0001);
    endtask

    task automatic pulse(input pcs_event_type ev);
        @(posedge i_mclk);
        i_event <= ev;
        @(posedge i_mclk);
        i_event <= '0;
    endtask

    task report_and_stop();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    // Status word sits in lanes 3:2; the command lanes are outside this slice.
    initial begin
        repeat (6) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        cfg_rd(6'h01, 4'hc);
        check("status reset", rd_val, 32'h0200_0000);
        cfg_wr(6'h01, 4'hc, 32'hffff_ffff);
        cfg_rd(6'h01, 4'hc);
        check("status ones", rd_val, 32'h0200_0000);
        for (int j = 0; j < 4; j++) begin
            pulse(pcs_event_type'(4'h1 << j));
            cfg_rd(6'h01, 4'h8);
            check("flag set", rd_val, 32'h0200_0000 | (32'h0800_0000 << j));
            cfg_wr(6'h01, 4'h8, 32'h0000_0000);
            cfg_rd(6'h01, 4'hc);
            check("flag kept", rd_val, 32'h0200_0000 | (32'h0800_0000 << j));
            cfg_wr(6'h01, 4'h8, 32'h0800_0000 << j);
            cfg_rd(6'h01, 4'hc);
            check("flag clear", rd_val, 32'h0200_0000);
        end
        pulse(pcs_event_type'(4'hf));
        // A write without lane 3 must not touch the flags.
        cfg_wr(6'h01, 4'h7, 32'hffff_ffff);
        cfg_rd(6'h01, 4'hc);
        check("all flags", rd_val, 32'h7a00_0000);
        cfg_rd(6'h01, 4'h4);
        check("status lane 2", rd_val, 32'h0000_0000);
        @(posedge i_mclk);
        i_pci_reset_input_n <= 1'b0;
        repeat (4) @(posedge i_mclk);
        i_pci_reset_input_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
        cfg_rd(6'h01, 4'hc);
        check("pin reset", rd_val, 32'h0200_0000);
        // An event seen while the clock enable is low must be dropped.
        i_ce <= 1'b0;
        pulse(pcs_event_type'(4'h8));
        i_ce <= 1'b1;
        cfg_rd(6'h01, 4'hc);
        check("frozen event", rd_val, 32'h0200_0000);
        cfg_wr(6'h02, 4'hf, 32'hffff_ffff);
        cfg_rd(6'h02, 4'hf);
        check("rev class", rd_val, {24'h06_0100, `PCS_REVISION_ID});
        cfg_rd(6'h02, 4'h1);
        check("rev byte", rd_val, {24'h00_0000, `PCS_REVISION_ID});
        cfg_rd(6'h02, 4'h8);
        check("base class", rd_val, 32'h0600_0000);
        cfg_rd(6'h03, 4'h4);
        check("header", rd_val, 32'h0000_0000);
        cfg_rd(6'h10, 4'hf);
        check("unmapped", rd_val, 32'h0000_0000);
        // Claim outputs: allow for the synchroniser and the two-cycle decode.
        i_isa_target_indication <= 1'b1;
        i_other_cycle <= 1'b1;
        repeat (5) @(posedge i_mclk);
        #1;
        check("sub claim", {30'h0, o_claim_positive, o_claim_subtractive}, 32'h0000_0001);
        @(posedge i_mclk);
        i_cfg_cycle <= 1'b1;
        repeat (3) @(posedge i_mclk);
        #1;
        check("pos claim", {30'h0, o_claim_positive, o_claim_subtractive}, 32'h0000_0002);
        @(posedge i_mclk);
        i_cfg_cycle <= 1'b0;
        i_isa_target_indication <= 1'b0;
        repeat (5) @(posedge i_mclk);
        #1;
        check("no claim", {30'h0, o_claim_positive, o_claim_subtractive}, 32'h0000_0000);
        report_and_stop();
    end

    // Watchdog at 20000 cycles, far beyond the fewer than 150 cycles the tests need.
    initial begin
        #200000;
        num_errors++;
        report_and_stop();
    end
endmodule
